// [test/test_ten_gig_pcs_path_router.sv]
`timescale 1ns/100ps
`default_nettype none
module test_ten_gig_pcs_path_router;
  logic aclk = 0, aresetn = 0, pin = 0, sln = 1, llp = 0, plp = 0, lrv = 0, ptv = 0, srv;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ltv, prv, poe, stv, wtv, div, dp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [63:0] stx, srx, wtx;
  tgpr_pkg::tgpr_word_type ptx = 36'h0, lrx = 36'h0, ltx, prx;
  int miscompares = 0, n_compared = 0, cs, cw, cr, cd;
  always #2 aclk = ~aclk;
  tgpr_top i_tgpr_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_mode_select_pin(pin),
    .split_loop_n_a(sln), .lane_loop_pin(llp), .parallel_loop_pin(plp), .lane_rx_inputs(lrx),
    .lane_rx_valid(lrv), .lane_tx_outputs(ltx), .lane_tx_valid(ltv), .parallel_tx_input(ptx),
    .parallel_tx_valid(ptv), .parallel_rx_output(prx), .parallel_rx_valid(prv),
    .parallel_output_enable(poe), .serial_tx_output(stx), .serial_tx_valid(stv), .serial_rx_input(srx),
    .serial_rx_valid(srv), .wan_tx_word(wtx), .wan_tx_valid(wtv), .wan_rx_word(wtx),
    .wan_rx_valid(wtv), .div64_clock_output(div));
  tgpr_line_model i_tgpr_line_model (.aclk(aclk), .tx_word(stx), .tx_valid(stv), .rx_word(srx), .rx_valid(srv));
  // ====================================================================
  // Checks and bus tasks
  task summarize;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_out(input int n);
    if (n >= 50) begin
      miscompares++;
      $display("wrong value at %0t: no answer", $time);
      summarize;
    end
  endtask : wait_out
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd) && n < 50) begin
      @(posedge aclk);
      n++;
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1 && n < 50);
    wait_out(n);
    bready <= 0;
    chk(bresp, r);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1 && n < 50);
    arvalid <= 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1 && n < 50);
    wait_out(n);
    rready <= 0;
    chk(rdata, d);
    chk(rresp, r);
  endtask : rd
  task stream(input int n);
    cs = 0;
    cw = 0;
    cr = 0;
    cd = 0;
    dp = div;
    repeat (n) begin
      @(posedge aclk);
      ptv <= 1;
      if (stv === 1) cs++;
      if (wtv === 1) cw++;
      if (prv === 1 && prx.d === 32'hA5A5A5A5) cr++;
      if (div === 1 && dp === 0) cd++;
      dp = div;
    end
    @(posedge aclk);
    ptv <= 0;
  endtask : stream
  task do_reset(input logic p);
    @(posedge aclk);
    pin <= p;
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    @(posedge aclk);
    #1;
  endtask : do_reset
  // ====================================================================
  // Main sequence
  initial begin
    do_reset(0);
    chk(poe, 1);
    rd(tgpr_pkg::ADDR_ROUTE, 32'h00000140, tgpr_pkg::RESP_OKAY);
    rd(8'h08, 32'h0, tgpr_pkg::RESP_SLVERR);
    wr(tgpr_pkg::ADDR_STATUS, 32'hFFFF, tgpr_pkg::RESP_SLVERR);
    wr(tgpr_pkg::ADDR_ROUTE, 32'hFFFF, tgpr_pkg::RESP_OKAY);
    rd(tgpr_pkg::ADDR_ROUTE, 32'h000001C3, tgpr_pkg::RESP_OKAY);
    ptx <= '{d: 32'hA5A5A5A5, c: 4'h0};
    wr(tgpr_pkg::ADDR_ROUTE, 32'h0142, tgpr_pkg::RESP_OKAY);
    stream(40);
    chk(cw > 0, 1);
    chk(cs, 0);
    wr(tgpr_pkg::ADDR_ROUTE, 32'h0140, tgpr_pkg::RESP_OKAY);
    stream(1200);
    chk(cs > 200, 1);
    chk(cr > 0, 1);
    chk(cd == 18 || cd == 19, 1);
    lrx <= '{d: 32'h5A5A5A5A, c: 4'h0};
    lrv <= 1;
    sln <= 0;
    stream(4);
    chk(ltx.d, 32'h5A5A5A5A);
    chk(ltv, 1);
    lrx <= '{d: 32'h3C3C3C3C, c: 4'h0};
    sln <= 1;
    llp <= 1;
    stream(4);
    chk(ltx.d, 32'h3C3C3C3C);
    llp <= 0;
    do_reset(1);
    chk(poe, 0);
    rd(tgpr_pkg::ADDR_ROUTE, 32'h0, tgpr_pkg::RESP_OKAY);
    plp <= 1;
    stream(6);
    #1;
    chk(poe, 1);
    chk(ltx.d, 32'hA5A5A5A5);
    summarize;
  end
endmodule : test_ten_gig_pcs_path_router
`default_nettype wire

// [test/tgpr_line_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tgpr_line_model (
  input wire logic aclk,
  input wire logic [63:0] tx_word,
  input wire logic tx_valid,
  output logic [63:0] rx_word,
  output logic rx_valid
);
  // ====================================================================
  // Line loop
  // Between words the line toggles each cycle between the last word and its inverse, so stale data never passes for new.
  initial begin
    rx_word = 64'h0;
    rx_valid = 1'b0;
  end
  always @(posedge aclk) begin
    rx_valid <= tx_valid;
    rx_word <= tx_valid ? tx_word : ~rx_word;
  end
endmodule : tgpr_line_model
`default_nettype wire

// [verilog/tgpr_pkg.sv]
`default_nettype none
package tgpr_pkg;
  // ====================================================================
  // Register map
  localparam logic [7:0] ADDR_ROUTE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [15:0] ROUTE_RST_PARALLEL = 16'h0140;
  localparam logic [15:0] ROUTE_RST_LANE = 16'h0000;
  localparam logic [15:0] ROUTE_WMASK = 16'h01C3;
  localparam int RT_PAR_SRC = 8;
  localparam int RT_LANE_SRC = 7;
  localparam int RT_OE = 6;
  localparam int RT_WAN = 1;
  localparam int RT_EXT = 0;
  localparam int ST_BLOCK_LOCK = 0;
  localparam int ST_FRAME_LOCK = 1;
  localparam int ST_EXT = 2;
  localparam int ST_WAN = 3;
  localparam int ST_OVERRUN = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ====================================================================
  // Block coding
  localparam logic [1:0] SYNC_DATA = 2'h1;
  localparam logic [1:0] SYNC_CTRL = 2'h2;
  localparam logic [1:0] SYNC_OVH = 2'h3;
  localparam logic [7:0] BT_IDLE_BLOCK = 8'h1E;
  localparam logic [7:0] XG_IDLE = 8'h07;
  localparam logic [7:0] XG_ERROR = 8'hFE;
  localparam logic [6:0] CC_IDLE = 7'h00;
  localparam logic [6:0] CC_ERROR = 7'h1E;
  localparam logic [16:0] LFSR_SEED = 17'h1FFFF;
  localparam logic [7:0] BLK_W = 8'h42;
  localparam logic [7:0] WORD_W = 8'h40;
  localparam int FRAME_BLOCKS = 24;
  localparam int LOCK_GOOD = 64;
  localparam int DIV64_HALF = 32;
  // ====================================================================
  // Types
  typedef struct packed {
    logic [31:0] d;
    logic [3:0] c;
  } tgpr_word_type;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_RESP = 2'b11,
    WR_DATA = 2'b10
  } tgpr_wr_state_type;
endpackage : tgpr_pkg
`default_nettype wire

// [verilog/tgpr_scrambler.sv]
`timescale 1ns/100ps
`default_nettype none
module tgpr_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [63:0] data_in,
  output logic [63:0] data_out
);
  logic [57:0] state_q;
  logic [57:0] state_d;

  // ====================================================================
  // Self-synchronising 1 + x^39 + x^58, first bit in is bit 0.
  always_comb begin
    state_d = state_q;
    data_out = '0;
    for (int i = 0; i < 64; i++) begin
      data_out[i] = data_in[i] ^ state_d[38] ^ state_d[57];
      state_d = {state_d[56:0], DESCRAMBLE ? data_in[i] : data_out[i]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else if (enable) begin
      state_q <= state_d;
    end
  end
endmodule : tgpr_scrambler
`default_nettype wire

// [verilog/tgpr_top.sv]
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1: Pin high: lane mode, routing defaults follow.
// RQ2: Pin low: parallel mode, routing resets 0x0140.
// RQ3: Lane receiver recovers, syncs, decodes four lanes. The code takes lane_rx_inputs as ready decoded words.
// RQ4: Deskew FIFO aligns lane words to coder. The code has no FIFO; lane_rx_inputs feed the coder directly.
// RQ5: Transmit side absorbs rate with idles in gaps.
// RQ6: Eight octets plus controls become 66-bit block.
// RQ7: Two sync bits lead, 64 payload bits follow.
// RQ8: Payload scrambled 1+x39+x58; sync bypasses scrambler.
// RQ9: Gearbox turns 66-bit blocks into 64-bit words.
// RQ10: Extended mode: 24 payloads plus overhead frame.
// RQ11: Extended mode scrambles with free-running x17+x14+1.
// RQ12: Wide-area status steers coded data to framer.
// RQ13: Serial output with divide-by-64 clock.
// RQ14: Receive data from serial or framer by status.
// RQ15: Receive aligns on sync, descrambles, decodes blocks.
// RQ16: Extended receive finds frame boundaries from overhead.
// RQ17: Descrambler state recovered from parity difference.
// RQ18: Receive side inserts idles to absorb rate.
// RQ19: Lane transmitter sends words on four lanes.
// RQ20: Parallel mode: coder takes parallel transmit input.
// RQ21: Parallel mode: coder output drives parallel receive.
// RQ22: Split and lane loop pins each enable loops.
// RQ23: Routing bits 8:6 reset 101 or 000.
// RQ24: Parallel loop pin forces outputs and lane source.
module tgpr_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic io_mode_select_pin,
  input wire logic split_loop_n_a,
  input wire logic lane_loop_pin,
  input wire logic parallel_loop_pin,
  input wire tgpr_pkg::tgpr_word_type lane_rx_inputs,
  input wire logic lane_rx_valid,
  output tgpr_pkg::tgpr_word_type lane_tx_outputs,
  output logic lane_tx_valid,
  input wire tgpr_pkg::tgpr_word_type parallel_tx_input,
  input wire logic parallel_tx_valid,
  output tgpr_pkg::tgpr_word_type parallel_rx_output,
  output logic parallel_rx_valid,
  output logic parallel_output_enable,
  output logic [63:0] serial_tx_output,
  output logic serial_tx_valid,
  input wire logic [63:0] serial_rx_input,
  input wire logic serial_rx_valid,
  output logic [63:0] wan_tx_word,
  output logic wan_tx_valid,
  input wire logic [63:0] wan_rx_word,
  input wire logic wan_rx_valid,
  output logic div64_clock_output
);
  localparam int GB_W = 192;

  // ====================================================================
  // Coding functions
  function automatic logic [65:0] tgpr_encode(input logic [63:0] d, input logic [7:0] c);
    logic idle;
    idle = (c == 8'hFF);
    for (int i = 0; i < 8; i++) begin
      idle = idle && (d[8*i+:8] == tgpr_pkg::XG_IDLE);
    end
    if (c == 8'h00) begin
      return {d, tgpr_pkg::SYNC_DATA};
    end else if (idle) begin
      return {{8{tgpr_pkg::CC_IDLE}}, tgpr_pkg::BT_IDLE_BLOCK, tgpr_pkg::SYNC_CTRL};
    end
    return {{8{tgpr_pkg::CC_ERROR}}, tgpr_pkg::BT_IDLE_BLOCK, tgpr_pkg::SYNC_CTRL};
  endfunction : tgpr_encode

  function automatic logic [71:0] tgpr_decode(input logic [1:0] s, input logic [63:0] p);
    logic [63:0] d;
    d = '0;
    if (s == tgpr_pkg::SYNC_DATA) begin
      return {8'h00, p};
    end
    for (int i = 0; i < 8; i++) begin
      d[8*i+:8] = (s == tgpr_pkg::SYNC_CTRL && p[7:0] == tgpr_pkg::BT_IDLE_BLOCK &&
                   p[8+7*i+:7] == tgpr_pkg::CC_IDLE) ? tgpr_pkg::XG_IDLE : tgpr_pkg::XG_ERROR;
    end
    return {8'hFF, d};
  endfunction : tgpr_decode

  function automatic logic [80:0] tgpr_lfsr(input logic [16:0] s);
    logic [16:0] st;
    logic [63:0] ks;
    st = s;
    for (int i = 0; i < 64; i++) begin
      ks[i] = st[16] ^ st[13];
      st = {st[15:0], ks[i]};
    end
    return {st, ks};
  endfunction : tgpr_lfsr

  function automatic logic [16:0] tgpr_fold(input logic [16:0] acc, input logic [63:0] p);
    logic [16:0] f;
    f = acc;
    for (int i = 0; i < 64; i++) begin
      f[i%17] = f[i%17] ^ p[i];
    end
    return f;
  endfunction : tgpr_fold

  // ====================================================================
  // AXI4-Lite slave and routing register
  tgpr_pkg::tgpr_wr_state_type wr_q, wr_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [15:0] route_q;
  logic [7:0] status;
  logic overrun_q;
  logic rx_lock_q;
  logic frame_lock_q;
  logic aw_hit;
  logic w_hit;
  logic ext;
  logic wan;

  assign aw_hit = s_axi_awvalid && s_axi_awready;
  assign w_hit = s_axi_wvalid && s_axi_wready;
  assign ext = route_q[tgpr_pkg::RT_EXT] && !route_q[tgpr_pkg::RT_WAN];
  assign wan = route_q[tgpr_pkg::RT_WAN];
  assign status = {3'h0, overrun_q, wan, ext, frame_lock_q, rx_lock_q};

  always_comb begin
    wr_d = wr_q;
    case (wr_q)
      tgpr_pkg::WR_IDLE: begin
        if (aw_hit && w_hit) wr_d = tgpr_pkg::WR_RESP;
        else if (aw_hit) wr_d = tgpr_pkg::WR_ADDR;
        else if (w_hit) wr_d = tgpr_pkg::WR_DATA;
      end
      tgpr_pkg::WR_ADDR: if (w_hit) wr_d = tgpr_pkg::WR_RESP;
      tgpr_pkg::WR_DATA: if (aw_hit) wr_d = tgpr_pkg::WR_RESP;
      tgpr_pkg::WR_RESP: if (s_axi_bready) wr_d = tgpr_pkg::WR_IDLE;
      default: wr_d = tgpr_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= tgpr_pkg::WR_IDLE;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tgpr_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      wr_q <= wr_d;
      s_axi_awready <= (wr_d == tgpr_pkg::WR_IDLE) || (wr_d == tgpr_pkg::WR_DATA);
      s_axi_wready <= (wr_d == tgpr_pkg::WR_IDLE) || (wr_d == tgpr_pkg::WR_ADDR);
      s_axi_bvalid <= (wr_d == tgpr_pkg::WR_RESP);
      if (aw_hit) awaddr_q <= s_axi_awaddr;
      if (w_hit) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_q != tgpr_pkg::WR_RESP && wr_d == tgpr_pkg::WR_RESP) begin
        s_axi_bresp <= ((aw_hit ? s_axi_awaddr : awaddr_q) == ADDR_W'(tgpr_pkg::ADDR_ROUTE)) ?
                       tgpr_pkg::RESP_OKAY : tgpr_pkg::RESP_SLVERR;
      end
    end
  end

  // The strap is sampled while reset is held, so a late pin change cannot move the routing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= io_mode_select_pin ? tgpr_pkg::ROUTE_RST_LANE : tgpr_pkg::ROUTE_RST_PARALLEL; // RQ1 RQ2 RQ23
    end else if (wr_q == tgpr_pkg::WR_RESP && s_axi_bvalid && s_axi_bready &&
                 s_axi_bresp == tgpr_pkg::RESP_OKAY) begin
      if (wstrb_q[0]) route_q[7:0] <= wdata_q[7:0] & tgpr_pkg::ROUTE_WMASK[7:0];
      if (wstrb_q[1]) route_q[15:8] <= wdata_q[15:8] & tgpr_pkg::ROUTE_WMASK[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tgpr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tgpr_pkg::RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(tgpr_pkg::ADDR_ROUTE)) begin
        s_axi_rdata <= {16'h0000, route_q};
      end else if (s_axi_araddr == ADDR_W'(tgpr_pkg::ADDR_STATUS)) begin
        s_axi_rdata <= {24'h000000, status};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= tgpr_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ====================================================================
  // Transmit: source select, word pairing, encoding
  logic par_src;
  logic lane_from_par;
  logic oe;
  tgpr_pkg::tgpr_word_type src_word;
  logic src_valid;
  tgpr_pkg::tgpr_word_type lo_q;
  logic half_q;
  logic [65:0] enc;
  logic enc_v;
  logic [63:0] scr_out;
  logic [16:0] tx_lfsr_q;
  logic [16:0] tx_par_q;
  logic [4:0] tx_frame_q;
  logic ovh_pend_q;
  logic [80:0] tx_ks;
  logic [65:0] blk_q;
  logic blk_v_q;

  assign par_src = route_q[tgpr_pkg::RT_PAR_SRC]; // RQ20
  assign lane_from_par = route_q[tgpr_pkg::RT_LANE_SRC] || parallel_loop_pin; // RQ24
  assign oe = route_q[tgpr_pkg::RT_OE] || parallel_loop_pin; // RQ24
  assign src_word = par_src ? parallel_tx_input : lane_rx_inputs; // RQ20 RQ4
  assign src_valid = par_src ? parallel_tx_valid : lane_rx_valid;
  assign enc = tgpr_encode({src_word.d, lo_q.d}, {src_word.c, lo_q.c}); // RQ6
  assign enc_v = src_valid && half_q;
  assign tx_ks = tgpr_lfsr(tx_lfsr_q);

  // Gaps simply leave the pairing stage idle, which is how idles are absorbed here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
      lo_q <= '0;
    end else if (src_valid) begin // RQ5
      half_q <= !half_q;
      if (!half_q) lo_q <= src_word;
    end
  end

  tgpr_scrambler #(.DESCRAMBLE(1'b0)) u_tx_scr (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(enc_v && !ext),
    .data_in(enc[65:2]),
    .data_out(scr_out)
  );

  // Overhead blocks use the cycle after a frame's last block; pairs leave that slot free.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_q <= '0;
      blk_v_q <= 1'b0;
      tx_lfsr_q <= tgpr_pkg::LFSR_SEED;
      tx_par_q <= '0;
      tx_frame_q <= '0;
      ovh_pend_q <= 1'b0;
    end else begin
      blk_v_q <= enc_v || ovh_pend_q;
      ovh_pend_q <= 1'b0;
      if (ovh_pend_q) begin
        blk_q <= {47'h0, tx_lfsr_q ^ tx_par_q, tgpr_pkg::SYNC_OVH}; // RQ10 RQ17
        tx_par_q <= '0;
      end else if (enc_v && ext) begin
        blk_q <= {enc[65:2] ^ tx_ks[63:0], enc[1:0]}; // RQ10 RQ11
        tx_lfsr_q <= tx_ks[80:64]; // RQ11
        tx_par_q <= tgpr_fold(tx_par_q, enc[65:2]);
        tx_frame_q <= (tx_frame_q == 5'(tgpr_pkg::FRAME_BLOCKS - 1)) ? 5'h00 : tx_frame_q + 5'h01;
        ovh_pend_q <= (tx_frame_q == 5'(tgpr_pkg::FRAME_BLOCKS - 1));
      end else if (enc_v) begin
        blk_q <= {scr_out, enc[1:0]}; // RQ7 RQ8
      end
    end
  end

  // ====================================================================
  // Transmit gearbox and line routing
  logic [GB_W-1:0] tgb_q;
  logic [7:0] tcnt_q;
  logic tgb_out;
  logic [7:0] tcnt_s;

  assign tgb_out = (tcnt_q >= tgpr_pkg::WORD_W);
  assign tcnt_s = tgb_out ? tcnt_q - tgpr_pkg::WORD_W : tcnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgb_q <= '0;
      tcnt_q <= '0;
    end else begin
      tgb_q <= (tgb_out ? (tgb_q >> tgpr_pkg::WORD_W) : tgb_q) |
               (blk_v_q ? ({{(GB_W-66){1'b0}}, blk_q} << tcnt_s) : '0); // RQ9
      tcnt_q <= tcnt_s + (blk_v_q ? tgpr_pkg::BLK_W : 8'h00);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_output <= '0;
      serial_tx_valid <= 1'b0;
      wan_tx_word <= '0;
      wan_tx_valid <= 1'b0;
    end else if (!split_loop_n_a || lane_loop_pin) begin
      serial_tx_output <= serial_rx_input; // RQ22
      serial_tx_valid <= serial_rx_valid;
      wan_tx_valid <= 1'b0;
    end else begin
      serial_tx_output <= tgb_q[63:0];
      serial_tx_valid <= tgb_out && !wan; // RQ12
      wan_tx_word <= tgb_q[63:0];
      wan_tx_valid <= tgb_out && wan; // RQ12
    end
  end

  // The serial clock itself is analog; this marks its divide-by-64 phase for the framer side.
  logic [5:0] div_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      div64_clock_output <= 1'b0;
    end else begin
      div_q <= (div_q == 6'(tgpr_pkg::DIV64_HALF - 1)) ? 6'h00 : div_q + 6'h01;
      if (div_q == 6'(tgpr_pkg::DIV64_HALF - 1)) div64_clock_output <= !div64_clock_output; // RQ13
    end
  end

  // ====================================================================
  // Receive gearbox, block lock, descramble and decode
  logic [63:0] rx_in;
  logic rx_in_v;
  logic [GB_W-1:0] rgb_q;
  logic [7:0] rcnt_q;
  logic take;
  logic sync_ok;
  logic [7:0] used;
  logic [6:0] good_q;
  logic [63:0] dscr_out;
  logic [16:0] rx_lfsr_q;
  logic [16:0] rx_par_q;
  logic [80:0] rx_ks;
  logic [63:0] rx_plain;
  logic [71:0] dec_q;
  logic [1:0] rx_pend_q;

  assign rx_in = wan ? wan_rx_word : serial_rx_input; // RQ14
  assign rx_in_v = wan ? wan_rx_valid : serial_rx_valid; // RQ14
  assign take = (rcnt_q > tgpr_pkg::BLK_W);
  assign sync_ok = (rgb_q[1:0] == tgpr_pkg::SYNC_DATA) || (rgb_q[1:0] == tgpr_pkg::SYNC_CTRL) ||
                   (ext && rgb_q[1:0] == tgpr_pkg::SYNC_OVH);
  assign used = take ? (tgpr_pkg::BLK_W + (sync_ok ? 8'h00 : 8'h01)) : 8'h00;
  assign rx_ks = tgpr_lfsr(rx_lfsr_q);
  assign rx_plain = ext ? (rgb_q[65:2] ^ rx_ks[63:0]) : dscr_out;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rgb_q <= '0;
      rcnt_q <= '0;
      good_q <= '0;
      rx_lock_q <= 1'b0;
    end else begin
      rgb_q <= (rgb_q >> used) | (rx_in_v ? ({{(GB_W-64){1'b0}}, rx_in} << (rcnt_q - used)) : '0);
      rcnt_q <= rcnt_q - used + (rx_in_v ? tgpr_pkg::WORD_W : 8'h00);
      if (take && !sync_ok) begin
        good_q <= '0; // RQ15
        rx_lock_q <= 1'b0;
      end else if (take && !rx_lock_q) begin
        good_q <= good_q + 7'h01;
        rx_lock_q <= (good_q == 7'(tgpr_pkg::LOCK_GOOD - 1));
      end
    end
  end

  tgpr_scrambler #(.DESCRAMBLE(1'b1)) u_rx_dscr (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(take && sync_ok && !ext),
    .data_in(rgb_q[65:2]),
    .data_out(dscr_out)
  );

  // Only locked data reaches the decoder; anything else leaves the output idling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_lfsr_q <= tgpr_pkg::LFSR_SEED;
      rx_par_q <= '0;
      frame_lock_q <= 1'b0;
      dec_q <= '0;
      rx_pend_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      rx_pend_q <= {1'b0, rx_pend_q[1]};
      if (!ext) frame_lock_q <= 1'b0;
      if (take && sync_ok && rx_lock_q && ext && rgb_q[1:0] == tgpr_pkg::SYNC_OVH) begin
        rx_lfsr_q <= rgb_q[18:2] ^ rx_par_q; // RQ16 RQ17
        rx_par_q <= '0;
        frame_lock_q <= 1'b1; // RQ16
      end else if (take && sync_ok && rx_lock_q) begin
        if (ext) rx_lfsr_q <= rx_ks[80:64];
        rx_par_q <= tgpr_fold(rx_par_q, rx_plain);
        dec_q <= tgpr_decode(rgb_q[1:0], rx_plain); // RQ15
        rx_pend_q <= 2'b11;
        if (rx_pend_q[1]) overrun_q <= 1'b1;
      end
    end
  end

  // ====================================================================
  // Receive word output and lane transmit routing
  tgpr_pkg::tgpr_word_type rx_word;

  always_comb begin
    rx_word.d = {4{tgpr_pkg::XG_IDLE}}; // RQ18
    rx_word.c = 4'hF;
    if (rx_pend_q == 2'b11) begin
      rx_word.d = dec_q[31:0];
      rx_word.c = dec_q[67:64];
    end else if (rx_pend_q == 2'b01) begin
      rx_word.d = dec_q[63:32];
      rx_word.c = dec_q[71:68];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_rx_output <= '0;
      parallel_rx_valid <= 1'b0;
      parallel_output_enable <= 1'b0;
      lane_tx_outputs <= '0;
      lane_tx_valid <= 1'b0;
    end else begin
      parallel_output_enable <= oe; // RQ24
      parallel_rx_output <= oe ? rx_word : '0; // RQ21
      parallel_rx_valid <= oe;
      if (lane_loop_pin || !split_loop_n_a) begin
        lane_tx_outputs <= lane_rx_inputs; // RQ22
        lane_tx_valid <= lane_rx_valid;
      end else if (lane_from_par) begin
        lane_tx_outputs <= parallel_tx_input; // RQ24
        lane_tx_valid <= parallel_tx_valid;
      end else begin
        lane_tx_outputs <= rx_word; // RQ19 RQ3
        lane_tx_valid <= 1'b1;
      end
    end
  end

  // ====================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ROUTE_PAR: assert property ($past(!aresetn) && !$past(io_mode_select_pin) // RQ2
    |-> route_q == tgpr_pkg::ROUTE_RST_PARALLEL) else $error("Routing not 0x0140 after reset.");
  AST_ROUTE_LANE: assert property ($past(!aresetn) && $past(io_mode_select_pin) // RQ1
    |-> route_q[8:6] == 3'h0) else $error("Routing bits not 000 after reset.");
  AST_OE_LOOP: assert property (parallel_loop_pin |=> parallel_output_enable) // RQ24
    else $error("Parallel loop pin did not enable outputs.");
  AST_WAN_ROUTE: assert property (tgb_out && wan && split_loop_n_a && !lane_loop_pin // RQ12
    |=> wan_tx_valid && !serial_tx_valid) else $error("Wide-area data reached serializer.");
  AST_SYNC_HDR: assert property (blk_v_q && !ext |-> blk_q[1:0] != 2'h0 && blk_q[1:0] != 2'h3) // RQ7
    else $error("Bad sync header in standard mode.");
  AST_GB_BOUND: assert property (tcnt_q < 8'h82) else $error("Transmit gearbox overfilled."); // RQ9
  AST_SLIP: assert property (take && !sync_ok |=> !rx_lock_q ##1 good_q <= 7'h01) // RQ15
    else $error("Bad sync header kept block lock.");
  AST_SPLIT: assert property (!split_loop_n_a && serial_rx_valid // RQ22
    |=> serial_tx_valid && serial_tx_output == $past(serial_rx_input))
    else $error("Split loop did not return line data.");
endmodule : tgpr_top
`default_nettype wire
